// [hdl/pmwd_pkg.sv]
// Purpose: Shared constants of the power mode and watchdog register bank.
// Assumes: 100 MHz core clock, 8-bit registers, 5-bit register address.
// Notes: Period tables are in milliseconds, indexed by the 3-bit code.
`default_nettype none
package pmwd_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [4:0] PMWD_ADDR_WD_ACCESS = 5'h02;
    localparam logic [4:0] PMWD_ADDR_WD_TIMING = 5'h03;
    localparam logic [4:0] PMWD_ADDR_WD_SERVICE = 5'h04;
    localparam logic [4:0] PMWD_ADDR_SUPPLY_EN = 5'h05;
    localparam logic [4:0] PMWD_ADDR_MODE_CTRL = 5'h06;
    localparam logic [4:0] PMWD_ADDR_INT_SUMMARY = 5'h07;

    // ------------------------------------------------------------------
    // Reset values and keys
    // ------------------------------------------------------------------
    localparam logic [7:0] PMWD_RST_WD_ACCESS = 8'h00;
    localparam logic [7:0] PMWD_RST_WD_TIMING = 8'h09;
    localparam logic [7:0] PMWD_RST_WD_SERVICE = 8'h00;
    localparam logic [7:0] PMWD_RST_SUPPLY_EN = 8'h6d;
    localparam logic [1:0] PMWD_RST_MODE = 2'h0;
    localparam logic [7:0] PMWD_WD_UNLOCK_KEY = 8'h5a;
    localparam logic [1:0] PMWD_WD_OFF_CODE = 2'h1;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int PMWD_WD_EN_LSB = 6;
    localparam int PMWD_WD_TMO_LSB = 3;
    localparam int PMWD_WD_WIN_LSB = 0;
    localparam int PMWD_SRV_TRIG_BIT = 0;
    localparam int PMWD_SUP_R3_STBY = 7;
    localparam int PMWD_SUP_R3_RXO = 6;
    localparam int PMWD_SUP_R3_NORM = 5;
    localparam int PMWD_SUP_R2_STBY = 4;
    localparam int PMWD_SUP_R2_RXO = 3;
    localparam int PMWD_SUP_R2_NORM = 2;
    localparam int PMWD_SUP_CONV_SLEEP = 1;
    localparam int PMWD_MODE_REQ_LSB = 0;
    localparam int PMWD_MODE_STATE_LSB = 4;
    localparam int PMWD_INT_BUS_BIT = 0;
    localparam int PMWD_INT_WAKE_BIT = 1;
    localparam int PMWD_INT_SUPPLY_BIT = 2;

    // ------------------------------------------------------------------
    // Operating modes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PMWD_MODE_STANDBY = 2'h0,
        PMWD_MODE_NORMAL = 2'h1,
        PMWD_MODE_RXONLY = 2'h2,
        PMWD_MODE_SLEEP = 2'h3
    } pmwd_mode_type;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int PMWD_CLK_PERIOD_NS = 10;
    localparam int PMWD_MS_NS = 1000000;
    localparam int PMWD_TICK_CYCLES = PMWD_MS_NS / PMWD_CLK_PERIOD_NS;

    // Window periods, code 7 down to code 0
    localparam logic [7:0][11:0] PMWD_WIN_MS = {
        12'h190, 12'h140, 12'h0f0, 12'h0a0, 12'h078, 12'h050, 12'h028, 12'h00a
    };
    // Timeout periods, code 7 down to code 0
    localparam logic [7:0][11:0] PMWD_TMO_MS = {
        12'hfa0, 12'h7d0, 12'h3e8, 12'h320, 12'h1e0, 12'h140, 12'h0a0, 12'h050
    };

endpackage
`default_nettype wire

// [hdl/pmwd_regs.sv]
// Purpose: Power mode, supply enable, watchdog and interrupt summary registers.
// Assumes: Register port driven by a serial engine on the core clock.
// Notes: Interrupt sources arrive from analog logic and are resynchronised.
//
// How it works
// R1: Window code in watchdog bits 2..0 picks 10 to 400 ms.
// R2: Window mode accepts service only in the second half of the period.
// R3: Software services the watchdog by writing one to service bit 0.
// R4: Service restarts the watchdog count; service bit then clears itself.
// R5: Supply bits 7,6,5 enable third regulator in standby, receive-only, normal.
// R6: Supply bits 4,3,2 enable second regulator in standby, receive-only, normal.
// R7: Supply bit 1 keeps the converter on in sleep; reset value 0x6d.
// R8: Summary bit 2 shows a pending supply interrupt.
// R9: Summary bit 1 shows a pending wake-up or temperature interrupt.
// R10: Summary bit 0 shows bus or local failure; bits 7..3 read zero.
// R11: Timeout code in watchdog bits 5..3 picks 80 to 4000 ms.
// R12: Watchdog timing writes only land while the access key 0x5a is held.
// R13: Mode bits 1..0 request standby, normal, receive-only or sleep.
// R14: Mode bits 5..4 read back the device state; writes ignored.
`timescale 1ns/10ps
`default_nettype none
module pmwd_regs #(
    parameter int TICK_CYCLES = pmwd_pkg::PMWD_TICK_CYCLES
) (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic [4:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_rd,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_rvalid,
    input wire logic [7:0] i_bus_fail_src,
    input wire logic [7:0] i_wake_temp_src,
    input wire logic [7:0] i_supply_src,
    output logic o_third_regulator_en,
    output logic o_second_regulator_en,
    output logic o_converter_en,
    output logic o_wd_fault
);
    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_s1_reg;
    logic rst_s2_reg;

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] wd_access;
        logic [7:0] wd_timing;
        logic [7:0] wd_service;
        logic [7:0] supply_en;
        logic [1:0] req_mode;
        logic [1:0] dev_state;
        logic [23:0] src_s1;
        logic [23:0] src_s2;
        logic [23:0] src_s3;
        logic [23:0] src_filt;
        logic [7:0] rdata;
        logic rvalid;
        logic third_en;
        logic second_en;
        logic conv_en;
        logic wd_fault;
    } pmwd_bank_reg_type;

    pmwd_bank_reg_type r_reg;
    pmwd_bank_reg_type r_next;

    pmwd_wd_if wd_bus ();

    pmwd_wdog #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_wdog (
        .i_core_clk(i_core_clk),
        .i_rst_n(rst_s2_reg),
        .wd(wd_bus)
    );

    // ------------------------------------------------------------------
    // Interrupt source filter
    // ------------------------------------------------------------------
    logic [23:0] filt_next;

    genvar gi;
    generate
        for (gi = 0; gi < 24; gi++) begin : g_filt
            // A level counts once the second and third stages agree
            assign filt_next[gi] = (r_reg.src_s2[gi] == r_reg.src_s3[gi]) ?
                r_reg.src_s3[gi] : r_reg.src_filt[gi];
        end
    endgenerate

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    logic [7:0] int_summary;
    logic [7:0] mode_rb;
    logic [7:0] rd_mux;

    always_comb begin
        r_next = r_reg;
        r_next.src_s1 = {i_supply_src, i_wake_temp_src, i_bus_fail_src};
        r_next.src_s2 = r_reg.src_s1;
        r_next.src_s3 = r_reg.src_s2;
        r_next.src_filt = filt_next;

        int_summary = 8'h00; // R10
        int_summary[pmwd_pkg::PMWD_INT_BUS_BIT] = |r_reg.src_filt[7:0]; // R10
        int_summary[pmwd_pkg::PMWD_INT_WAKE_BIT] = |r_reg.src_filt[15:8]; // R9
        int_summary[pmwd_pkg::PMWD_INT_SUPPLY_BIT] = |r_reg.src_filt[23:16]; // R8

        mode_rb = 8'h00;
        mode_rb[pmwd_pkg::PMWD_MODE_REQ_LSB +: 2] = r_reg.req_mode;
        mode_rb[pmwd_pkg::PMWD_MODE_STATE_LSB +: 2] = r_reg.dev_state; // R14

        // Service bit lives for one cycle only
        r_next.wd_service = pmwd_pkg::PMWD_RST_WD_SERVICE; // R4

        if (i_reg_wr) begin
            unique case (i_reg_addr)
                pmwd_pkg::PMWD_ADDR_WD_ACCESS: r_next.wd_access = i_reg_wdata;
                pmwd_pkg::PMWD_ADDR_WD_TIMING: begin
                    if (r_reg.wd_access == pmwd_pkg::PMWD_WD_UNLOCK_KEY) begin
                        r_next.wd_timing = i_reg_wdata; // R12
                    end
                end
                pmwd_pkg::PMWD_ADDR_WD_SERVICE: begin
                    r_next.wd_service[pmwd_pkg::PMWD_SRV_TRIG_BIT] =
                        i_reg_wdata[pmwd_pkg::PMWD_SRV_TRIG_BIT]; // R3
                end
                pmwd_pkg::PMWD_ADDR_SUPPLY_EN: r_next.supply_en = i_reg_wdata;
                pmwd_pkg::PMWD_ADDR_MODE_CTRL: begin
                    r_next.req_mode = i_reg_wdata[pmwd_pkg::PMWD_MODE_REQ_LSB +: 2]; // R13
                end
                default: begin
                end
            endcase
        end

        // Sleep leaves the last awake state in the read-back field
        if (r_reg.req_mode != pmwd_pkg::PMWD_MODE_SLEEP) begin
            r_next.dev_state = r_reg.req_mode; // R14
        end

        unique case (r_reg.req_mode)
            pmwd_pkg::PMWD_MODE_STANDBY: begin
                r_next.third_en = r_reg.supply_en[pmwd_pkg::PMWD_SUP_R3_STBY]; // R5
                r_next.second_en = r_reg.supply_en[pmwd_pkg::PMWD_SUP_R2_STBY]; // R6
                r_next.conv_en = 1'b1;
            end
            pmwd_pkg::PMWD_MODE_RXONLY: begin
                r_next.third_en = r_reg.supply_en[pmwd_pkg::PMWD_SUP_R3_RXO]; // R5
                r_next.second_en = r_reg.supply_en[pmwd_pkg::PMWD_SUP_R2_RXO]; // R6
                r_next.conv_en = 1'b1;
            end
            pmwd_pkg::PMWD_MODE_NORMAL: begin
                r_next.third_en = r_reg.supply_en[pmwd_pkg::PMWD_SUP_R3_NORM]; // R5
                r_next.second_en = r_reg.supply_en[pmwd_pkg::PMWD_SUP_R2_NORM]; // R6
                r_next.conv_en = 1'b1;
            end
            default: begin
                r_next.third_en = 1'b0;
                r_next.second_en = 1'b0;
                r_next.conv_en = r_reg.supply_en[pmwd_pkg::PMWD_SUP_CONV_SLEEP]; // R7
            end
        endcase

        unique case (i_reg_addr)
            pmwd_pkg::PMWD_ADDR_WD_ACCESS: rd_mux = r_reg.wd_access;
            pmwd_pkg::PMWD_ADDR_WD_TIMING: rd_mux = r_reg.wd_timing;
            pmwd_pkg::PMWD_ADDR_WD_SERVICE: rd_mux = r_reg.wd_service;
            pmwd_pkg::PMWD_ADDR_SUPPLY_EN: rd_mux = r_reg.supply_en;
            pmwd_pkg::PMWD_ADDR_MODE_CTRL: rd_mux = mode_rb;
            pmwd_pkg::PMWD_ADDR_INT_SUMMARY: rd_mux = int_summary;
            default: rd_mux = 8'h00;
        endcase
        r_next.rvalid = i_reg_rd;
        if (i_reg_rd) begin
            r_next.rdata = rd_mux;
        end
        r_next.wd_fault = wd_bus.fault;
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge rst_s2_reg) begin
        if (!rst_s2_reg) begin
            r_reg <= '0;
            r_reg.wd_access <= pmwd_pkg::PMWD_RST_WD_ACCESS;
            r_reg.wd_timing <= pmwd_pkg::PMWD_RST_WD_TIMING;
            r_reg.wd_service <= pmwd_pkg::PMWD_RST_WD_SERVICE; // R4
            r_reg.supply_en <= pmwd_pkg::PMWD_RST_SUPPLY_EN; // R7
            r_reg.req_mode <= pmwd_pkg::PMWD_RST_MODE;
            r_reg.dev_state <= pmwd_pkg::PMWD_RST_MODE;
        end else begin
            r_reg <= r_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs and watchdog hookup
    // ------------------------------------------------------------------
    assign wd_bus.cfg = r_reg.wd_timing;
    assign wd_bus.window_mode = (r_reg.dev_state == pmwd_pkg::PMWD_MODE_NORMAL);
    assign wd_bus.trigger = r_reg.wd_service[pmwd_pkg::PMWD_SRV_TRIG_BIT]; // R4

    assign o_reg_rdata = r_reg.rdata;
    assign o_reg_rvalid = r_reg.rvalid;
    assign o_third_regulator_en = r_reg.third_en;
    assign o_second_regulator_en = r_reg.second_en;
    assign o_converter_en = r_reg.conv_en;
    assign o_wd_fault = r_reg.wd_fault;
endmodule
`default_nettype wire

// [hdl/pmwd_wd_if.sv]
// Purpose: Carries watchdog settings and events between bank and timer.
// Assumes: Both ends on the core clock.
// Notes: trigger and fault are one-cycle pulses.
`timescale 1ns/10ps
`default_nettype none
interface pmwd_wd_if;
    logic [7:0] cfg;
    logic window_mode;
    logic trigger;
    logic fault;
    logic active;

    modport bank (
        output cfg,
        output window_mode,
        output trigger,
        input fault,
        input active
    );
    modport timer (
        input cfg,
        input window_mode,
        input trigger,
        output fault,
        output active
    );
endinterface
`default_nettype wire

// [hdl/pmwd_wdog.sv]
// Purpose: Window and timeout watchdog timer counting in millisecond ticks.
// Assumes: Asynchronous active-low reset from the bank, released on the core clock.
// Notes: The tick divider runs free, so a period may be up to 1 ms short.
`timescale 1ns/10ps
`default_nettype none
module pmwd_wdog #(
    parameter int TICK_CYCLES = pmwd_pkg::PMWD_TICK_CYCLES
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    pmwd_wd_if.timer wd
);
    localparam int DIVW = $clog2(TICK_CYCLES);

    typedef enum logic [3:0] {
        PMWD_WD_OFF = 4'h1,
        PMWD_WD_CLOSED = 4'h2,
        PMWD_WD_OPEN = 4'h4,
        PMWD_WD_TMO = 4'h8
    } pmwd_wd_state_type;

    typedef struct packed {
        pmwd_wd_state_type st;
        logic [DIVW-1:0] div;
        logic [11:0] cnt;
        logic last_mode;
        logic fault;
    } pmwd_wd_reg_type;

    pmwd_wd_reg_type r_reg;
    pmwd_wd_reg_type r_next;

    logic tick;
    logic enabled;
    logic [11:0] period;
    logic [11:0] half;
    logic [11:0] cnt_inc;

    always_comb begin
        r_next = r_reg;
        r_next.fault = 1'b0;
        tick = (r_reg.div == DIVW'(TICK_CYCLES - 1));
        r_next.div = tick ? '0 : DIVW'(r_reg.div + 1'b1);
        enabled = (wd.cfg[pmwd_pkg::PMWD_WD_EN_LSB +: 2] != pmwd_pkg::PMWD_WD_OFF_CODE);
        if (wd.window_mode) begin
            period = pmwd_pkg::PMWD_WIN_MS[wd.cfg[pmwd_pkg::PMWD_WD_WIN_LSB +: 3]]; // R1
        end else begin
            period = pmwd_pkg::PMWD_TMO_MS[wd.cfg[pmwd_pkg::PMWD_WD_TMO_LSB +: 3]]; // R11
        end
        half = {1'b0, period[11:1]};
        cnt_inc = 12'(r_reg.cnt + 12'h001);
        r_next.last_mode = wd.window_mode;
        if (!enabled) begin
            r_next.st = PMWD_WD_OFF;
            r_next.cnt = '0;
        end else if (r_reg.st == PMWD_WD_OFF || wd.window_mode != r_reg.last_mode) begin
            r_next.st = wd.window_mode ? PMWD_WD_CLOSED : PMWD_WD_TMO;
            r_next.cnt = '0;
        end else begin
            unique case (r_reg.st)
                PMWD_WD_CLOSED: begin
                    if (wd.trigger) begin
                        // Early service is refused and counts as a fault
                        r_next.fault = 1'b1; // R2
                        r_next.cnt = '0;
                    end else if (tick) begin
                        r_next.cnt = cnt_inc;
                        if (cnt_inc >= half) begin
                            r_next.st = PMWD_WD_OPEN; // R2
                        end
                    end
                end
                PMWD_WD_OPEN: begin
                    if (wd.trigger) begin
                        r_next.st = PMWD_WD_CLOSED; // R4
                        r_next.cnt = '0;
                    end else if (tick) begin
                        r_next.cnt = cnt_inc;
                        if (cnt_inc >= period) begin
                            r_next.fault = 1'b1;
                            r_next.st = PMWD_WD_CLOSED;
                            r_next.cnt = '0;
                        end
                    end
                end
                PMWD_WD_TMO: begin
                    if (wd.trigger) begin
                        r_next.cnt = '0; // R4
                    end else if (tick) begin
                        r_next.cnt = cnt_inc;
                        if (cnt_inc >= period) begin
                            r_next.fault = 1'b1;
                            r_next.cnt = '0;
                        end
                    end
                end
                default: begin
                    r_next.st = PMWD_WD_OFF;
                    r_next.cnt = '0;
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r_reg <= '{st: PMWD_WD_OFF, div: '0, cnt: '0, last_mode: 1'b0, fault: 1'b0};
        end else begin
            r_reg <= r_next;
        end
    end

    assign wd.fault = r_reg.fault;
    assign wd.active = (r_reg.st != PMWD_WD_OFF);
endmodule
`default_nettype wire

// [sim/pmwd_mcu_model.sv]
// Purpose: Microcontroller side of the register port.
// Assumes: Requests launched 1 ns after a rising edge.
// Notes: Released lines carry the inverse of the last value.
`timescale 1ns/10ps
`default_nettype none
module pmwd_mcu_model (
    input wire logic i_core_clk,
    input wire logic [7:0] i_rdata,
    input wire logic i_rvalid,
    output logic [4:0] o_addr,
    output logic o_wr,
    output logic [7:0] o_wdata,
    output logic o_rd
);
    int gap = 0;
    initial begin
        o_addr = 5'h1e;
        o_wr = 1'b0;
        o_wdata = 8'h00;
        o_rd = 1'b0;
    end
    task automatic write_reg(input logic [4:0] a, input logic [7:0] d);
        repeat (gap + 1) @(posedge i_core_clk);
        #1;
        o_addr = a;
        o_wdata = d;
        o_wr = 1'b1;
        @(posedge i_core_clk);
        #1;
        o_wr = 1'b0;
        o_addr = ~a;
        o_wdata = ~d;
    endtask
    // Service by writing one to the trigger bit
    task automatic service();
        write_reg(5'h04, 8'h01);
    endtask
    task automatic read_reg(input logic [4:0] a, output logic [7:0] d);
        repeat (gap + 1) @(posedge i_core_clk);
        #1;
        o_addr = a;
        o_rd = 1'b1;
        @(posedge i_core_clk);
        #1;
        o_rd = 1'b0;
        o_addr = ~a;
        d = (i_rvalid === 1'b1) ? i_rdata : 8'hxx;
    endtask
endmodule
`default_nettype wire

// [sim/pmwd_regs_props.sv]
// Purpose: Port assertions of the power mode register bank.
// Assumes: Writes to supply and mode registers always land.
// Notes: Shadow registers rebuild the expected enables.
`timescale 1ns/10ps
`default_nettype none
module pmwd_regs_props #(
    parameter int TICK_CYCLES = 10
) (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic [4:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_rd,
    input wire logic [7:0] o_reg_rdata,
    input wire logic o_reg_rvalid,
    input wire logic [7:0] i_bus_fail_src,
    input wire logic [7:0] i_wake_temp_src,
    input wire logic [7:0] i_supply_src,
    input wire logic o_third_regulator_en,
    input wire logic o_second_regulator_en,
    input wire logic o_converter_en,
    input wire logic o_wd_fault
);
    logic [7:0] sup_reg;
    logic [1:0] mode_reg;
    logic [2:0] age_reg;
    logic [2:0] calm_reg;
    logic [2:0] summ;
    logic t3, t2, tc, quiet;
    assign summ = {|i_supply_src, |i_wake_temp_src, |i_bus_fail_src};
    assign tc = (mode_reg == 2'h3) ? sup_reg[1] : 1'b1;
    always_comb begin
        case (mode_reg)
            2'h0: {t3, t2} = {sup_reg[7], sup_reg[4]};
            2'h1: {t3, t2} = {sup_reg[5], sup_reg[2]};
            2'h2: {t3, t2} = {sup_reg[6], sup_reg[3]};
            default: {t3, t2} = 2'b00;
        endcase
    end
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sup_reg <= 8'h6d;
            mode_reg <= 2'h0;
            age_reg <= 3'h0;
            calm_reg <= 3'h0;
            quiet <= 1'b0;
        end else begin
            if (i_reg_wr && i_reg_addr == 5'h05) begin
                sup_reg <= i_reg_wdata;
            end
            if (i_reg_wr && i_reg_addr == 5'h06) begin
                mode_reg <= i_reg_wdata[1:0];
            end
            if (age_reg != 3'h7) begin
                age_reg <= age_reg + 3'h1;
            end
            if (summ != $past(summ)) begin
                calm_reg <= 3'h0;
            end else if (calm_reg != 3'h7) begin
                calm_reg <= calm_reg + 3'h1;
            end
            quiet <= !i_reg_wr && (age_reg == 3'h7);
        end
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);
    property p_rd_answer; i_reg_rd |=> o_reg_rvalid; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read got no answer");
    property p_rd_lone; !i_reg_rd |=> !o_reg_rvalid; endproperty
    a_rd_lone: assert property (p_rd_lone) else $error("answer without read");
    property p_sum_rsvd; i_reg_rd && i_reg_addr == 5'h07 |=> o_reg_rdata[7:3] == 5'h00; endproperty
    a_sum_rsvd: assert property (p_sum_rsvd) else $error("summary high bits set");
    property p_sum_bits;
        i_reg_rd && i_reg_addr == 5'h07 && calm_reg == 3'h7 |=> o_reg_rdata[2:0] == $past(summ);
    endproperty
    a_sum_bits: assert property (p_sum_bits) else $error("summary bits wrong");
    property p_mode_rd;
        i_reg_rd && i_reg_addr == 5'h06 |=>
            {o_reg_rdata[7:6], o_reg_rdata[3:0]} == {4'h0, $past(mode_reg)};
    endproperty
    a_mode_rd: assert property (p_mode_rd) else $error("mode readback wrong");
    property p_sup_rd; i_reg_rd && i_reg_addr == 5'h05 |=> o_reg_rdata == $past(sup_reg);
    endproperty
    a_sup_rd: assert property (p_sup_rd) else $error("supply readback wrong");
    property p_fault_pulse; o_wd_fault |=> !o_wd_fault; endproperty
    a_fault_pulse: assert property (p_fault_pulse) else $error("fault longer than a cycle");
    property p_third; quiet && !$past(i_reg_wr) |-> o_third_regulator_en == t3; endproperty
    a_third: assert property (p_third) else $error("third regulator enable wrong");
    property p_second; quiet && !$past(i_reg_wr) |-> o_second_regulator_en == t2; endproperty
    a_second: assert property (p_second) else $error("second regulator enable wrong");
    property p_conv; quiet && !$past(i_reg_wr) |-> o_converter_en == tc; endproperty
    a_conv: assert property (p_conv) else $error("converter enable wrong");
endmodule
bind pmwd_regs pmwd_regs_props #(.TICK_CYCLES(TICK_CYCLES)) i_pmwd_regs_props (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_reg_addr(i_reg_addr),
    .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .i_bus_fail_src(i_bus_fail_src),
    .i_wake_temp_src(i_wake_temp_src), .i_supply_src(i_supply_src),
    .o_third_regulator_en(o_third_regulator_en), .o_second_regulator_en(o_second_regulator_en),
    .o_converter_en(o_converter_en), .o_wd_fault(o_wd_fault));
`default_nettype wire

// [sim/power_mode_watchdog_regs_tb.sv]
// Purpose: Self-checking bench of the power mode register bank.
// Assumes: One watchdog tick is 10 core cycles.
// Notes: Reference registers live in an associative array.
`timescale 1ns/10ps
`default_nettype none
module power_mode_watchdog_regs_tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] src [3] = '{8'h00, 8'h00, 8'h00};
    logic [4:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic wr, rd, rvalid, en3, en2, enc, fault;
    int error_cnt = 0;
    int samples_checked = 0;
    int faults = 0;
    logic [7:0] ref_mem [int];
    int state = 0;
    logic [31:0] lfsr = 32'hf97b;
    logic [31:0] r;
    logic [7:0] s;
    pmwd_regs #(.TICK_CYCLES(10)) i_pmwd_regs (.i_core_clk(clk), .i_resetn(rstn),
        .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wdata), .i_reg_rd(rd),
        .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_bus_fail_src(src[0]),
        .i_wake_temp_src(src[1]), .i_supply_src(src[2]), .o_third_regulator_en(en3),
        .o_second_regulator_en(en2), .o_converter_en(enc), .o_wd_fault(fault));
    pmwd_mcu_model i_pmwd_mcu_model (.i_core_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid),
        .o_addr(addr), .o_wr(wr), .o_wdata(wdata), .o_rd(rd));
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (fault === 1'b1) begin
            faults <= faults + 1;
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
        logic [7:0] d;
        i_pmwd_mcu_model.read_reg(a, d);
        check("read", d, exp);
    endtask
    task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
        i_pmwd_mcu_model.write_reg(a, d);
        if (a == 5'h03 && ref_mem[2] != 8'h5a) begin
            return;
        end
        if (a == 5'h06 && d[1:0] != 2'h3) begin
            state = d[1:0];
        end
        ref_mem[a] = (a == 5'h06) ? {2'h0, state[1:0], 2'h0, d[1:0]} : d;
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic wait_fault(input int lo, input int hi);
        int f0;
        int w;
        f0 = faults;
        for (w = 0; w < hi + 50 && faults == f0; w++) tick(1);
        if (faults == f0) begin
            error_cnt++;
            $display("[FAIL] %0t no fault got %h exp %h", $time, w, hi);
            close_out();
        end else check("fault time", {7'h0, w >= lo && w <= hi}, 8'h01);
    endtask
    initial begin
        ref_mem = '{2: 8'h00, 3: 8'h09, 4: 8'h00, 5: 8'h6d, 6: 8'h00};
        tick(12);
        rstn = 1'b1;
        tick(3);
        foreach (ref_mem[a]) rd_chk(a[4:0], ref_mem[a]);
        rd_chk(5'h07, 8'h00);
        rd_chk(5'h1f, 8'h00);
        $display("test reset done");
        wr_reg(5'h02, 8'h5b);
        wr_reg(5'h03, 8'h12);
        rd_chk(5'h03, ref_mem[3]);
        wr_reg(5'h02, 8'h5a);
        wr_reg(5'h03, 8'h36);
        rd_chk(5'h03, ref_mem[3]);
        wr_reg(5'h02, 8'h00);
        wr_reg(5'h03, 8'h00);
        rd_chk(5'h03, ref_mem[3]);
        $display("test lock done");
        i_pmwd_mcu_model.gap = 2;
        for (int m = 0; m < 8; m++) begin
            r = next_rand();
            wr_reg(5'h05, r[7:0] | 8'h01);
            r = next_rand();
            wr_reg(5'h06, {r[7:2], m[1:0]});
            tick(3);
            s = ref_mem[5];
            case (m % 4)
                0: check("enables", {en3, en2, enc}, {s[7], s[4], 1'b1});
                1: check("enables", {en3, en2, enc}, {s[5], s[2], 1'b1});
                2: check("enables", {en3, en2, enc}, {s[6], s[3], 1'b1});
                default: check("enables", {en3, en2, enc}, {2'b00, s[1]});
            endcase
            rd_chk(5'h06, ref_mem[6]);
            rd_chk(5'h05, ref_mem[5]);
        end
        i_pmwd_mcu_model.gap = 0;
        $display("test modes done");
        for (int b = 0; b < 4; b++) begin
            r = next_rand();
            for (int k = 0; k < 3; k++) src[k] = (b == k || b == 3) ? (r[7:0] | 8'h10) : 8'h00;
            tick(8);
            rd_chk(5'h07, (b == 3) ? 8'h07 : 8'h01 << b);
        end
        $display("test summary done");
        wr_reg(5'h06, 8'h00);
        wr_reg(5'h02, 8'h5a);
        wr_reg(5'h03, 8'h00);
        i_pmwd_mcu_model.service();
        r = faults;
        for (int k = 0; k < 4; k++) begin
            tick(400);
            i_pmwd_mcu_model.service();
        end
        check("timeout serviced", 8'(faults - r), 8'h00);
        rd_chk(5'h04, 8'h00);
        wait_fault(780, 810);
        wr_reg(5'h06, 8'h01);
        tick(70);
        r = faults;
        i_pmwd_mcu_model.service();
        tick(20);
        check("open window", 8'(faults - r), 8'h00);
        i_pmwd_mcu_model.service();
        wait_fault(0, 10);
        wait_fault(85, 105);
        $display("test watchdog done");
        close_out();
    end
    function automatic logic [31:0] next_rand();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
endmodule
`default_nettype wire
